//--- hw/rcl_link_timer.sv
// link-detect watchdog restarted by each valid reverse-channel reception
`timescale 1ns/1ps
module rcl_link_timer
  import rcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic [LD_CNT_W-1:0] i_limit,
  output logic o_link_detect,
  output logic o_expire
);

  typedef struct packed {
    logic [LD_CNT_W-1:0] cnt;
    logic detect;
    logic expire;
  } rcl_tmr_s;

  rcl_tmr_s st_r;
  rcl_tmr_s st_nxt;

  // a restart wins over expiry in the same cycle, so a reply at the deadline keeps the link
  always_comb begin
    st_nxt = st_r;
    st_nxt.expire = 1'b0;
    if (i_restart) begin
      st_nxt.cnt = '0;
      st_nxt.detect = 1'b1;
    end else if (st_r.detect) begin
      if (st_r.cnt >= i_limit - LD_CNT_W'(1)) begin
        st_nxt.cnt = '0;
        st_nxt.detect = 1'b0;
        st_nxt.expire = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + LD_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_link_detect = st_r.detect;
  assign o_expire = st_r.expire;

endmodule : rcl_link_timer

//--- hw/rcl_pkg.sv
// constants, field layout and carrier types of the remote capability and link detect block
package rcl_pkg;

  // register indices; the bus sees each one at four times its index
  localparam logic [5:0] CAP_A_IDX = 6'h20;
  localparam logic [5:0] CAP_B_IDX = 6'h21;
  localparam logic [5:0] LD_CTRL_IDX = 6'h26;
  localparam logic [5:0] STATUS_IDX = 6'h28;
  localparam logic [5:0] IRQ_STS_IDX = 6'h29;
  localparam logic [5:0] IRQ_CLR_IDX = 6'h2a;
  localparam logic [5:0] IRQ_EN_IDX = 6'h2b;

  // capability register field positions
  localparam int CAP_LOCK_BIT = 7;
  localparam int SEND_FREQ_BIT = 5;
  localparam int SEND_EQ_BIT = 4;
  localparam int TWO_LANE_BIT = 3;
  localparam int CHAN_SEL_BIT = 2;
  localparam int WIDE_VID_BIT = 1;
  localparam int FWD_PIN_BIT = 0;

  // status register field positions
  localparam int STS_LINK_BIT = 0;
  localparam int STS_LOCK_BIT = 1;

  // interrupt bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_LOADED = 0;
  localparam int IRQ_LINK_UP = 1;
  localparam int IRQ_LINK_DOWN = 2;

  // reset values
  localparam logic [7:0] CAP_A_RST = 8'h00;
  localparam logic [2:0] LD_CTRL_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

  // timeout codes
  localparam logic [2:0] LD_CODE_162US = 3'h0;
  localparam logic [2:0] LD_CODE_325US = 3'h1;
  localparam logic [2:0] LD_CODE_650US = 3'h2;
  localparam logic [2:0] LD_CODE_1300US = 3'h3;
  localparam logic [2:0] LD_CODE_10US = 3'h4;
  localparam logic [2:0] LD_CODE_20US = 3'h5;
  localparam logic [2:0] LD_CODE_82US = 3'h7;

  // timeout periods in ns and the clock period they are counted in
  localparam int CLK_PERIOD_NS = 10;
  localparam int LD_T162_NS = 162000;
  localparam int LD_T325_NS = 325000;
  localparam int LD_T650_NS = 650000;
  localparam int LD_T1300_NS = 1300000;
  localparam int LD_T10_NS = 10250;
  localparam int LD_T20_NS = 20500;
  localparam int LD_T82_NS = 82000;
  localparam int LD_CNT_W = 18;
  localparam logic [LD_CNT_W-1:0] LD_CYC_162 = LD_CNT_W'(LD_T162_NS / CLK_PERIOD_NS);
  localparam logic [LD_CNT_W-1:0] LD_CYC_325 = LD_CNT_W'(LD_T325_NS / CLK_PERIOD_NS);
  localparam logic [LD_CNT_W-1:0] LD_CYC_650 = LD_CNT_W'(LD_T650_NS / CLK_PERIOD_NS);
  localparam logic [LD_CNT_W-1:0] LD_CYC_1300 = LD_CNT_W'(LD_T1300_NS / CLK_PERIOD_NS);
  localparam logic [LD_CNT_W-1:0] LD_CYC_10 = LD_CNT_W'(LD_T10_NS / CLK_PERIOD_NS);
  localparam logic [LD_CNT_W-1:0] LD_CYC_20 = LD_CNT_W'(LD_T20_NS / CLK_PERIOD_NS);
  localparam logic [LD_CNT_W-1:0] LD_CYC_82 = LD_CNT_W'(LD_T82_NS / CLK_PERIOD_NS);

  // remote capability fields as the rest of the serializer sees them
  typedef struct packed {
    logic send_freq;
    logic send_eq;
    logic two_lane;
    logic chan_sel;
    logic wide_video;
    logic fwd_pin;
  } rcl_caps_s;

  // one back-channel report from the remote receiver
  typedef struct packed {
    logic valid;
    logic [7:0] caps;
  } rcl_bc_s;

endpackage : rcl_pkg

//--- hw/rcl_sync3.sv
// three-stage synchroniser for a level arriving from a pin
`timescale 1ns/1ps
module rcl_sync3 (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } rcl_sync_s;

  rcl_sync_s st_r;
  rcl_sync_s st_nxt;

  // the first stage feeds only the second; the level moves once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;

endmodule : rcl_sync3

//--- hw/rcl_top.sv
// remote capability register bank with back-channel auto-load and link-detect timeout
`timescale 1ns/1ps
module rcl_top
  import rcl_pkg::*;
#(
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_162 = LD_CYC_162,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_325 = LD_CYC_325,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_650 = LD_CYC_650,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_1300 = LD_CYC_1300,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_20 = LD_CYC_20,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_82 = LD_CYC_82
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // receiver lock from the link front end, asynchronous
  input wire logic i_rx_lock,
  // decoded back-channel reports, same clock
  input wire rcl_bc_s i_bc,
  // capability fields and link state towards the serializer, and the interrupt line
  output rcl_caps_s o_caps,
  output logic o_send_eq_train,
  output logic o_link_detect,
  output logic o_irq
);

  // whole register state of the bank
  typedef struct packed {
    logic cap_lock;
    rcl_caps_s caps;
    logic [2:0] ld_sel;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_en;
    logic ack;
    logic [31:0] rdata;
  } rcl_state_s;

  rcl_state_s st_r;
  rcl_state_s st_nxt;

  logic rx_lock_sync;
  logic link_detect;
  logic link_expire;
  logic link_prev_r;
  logic [LD_CNT_W-1:0] ld_limit;
  logic req;
  logic prep;
  logic wr_commit;
  logic wr_lane0;
  logic auto_load;
  rcl_caps_s bc_caps;
  logic [IRQ_W-1:0] irq_event;
  logic [7:0] cap_a_view;
  logic [7:0] ld_view;
  logic [7:0] sts_view;

  // true when the byte address selects the register at the given index
  function automatic logic addr_hit(input logic [7:0] addr, input logic [5:0] idx);
    addr_hit = (addr == {idx, 2'b00});
  endfunction : addr_hit

  // unpack a raw capability byte into its fields
  function automatic rcl_caps_s caps_of(input logic [7:0] raw);
    rcl_caps_s c;
    c.send_freq = raw[SEND_FREQ_BIT];
    c.send_eq = raw[SEND_EQ_BIT];
    c.two_lane = raw[TWO_LANE_BIT];
    c.chan_sel = raw[CHAN_SEL_BIT];
    c.wide_video = raw[WIDE_VID_BIT];
    c.fwd_pin = raw[FWD_PIN_BIT];
    caps_of = c;
  endfunction : caps_of

  // receiver lock comes from another domain
  rcl_sync3 u_lock_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_rx_lock),
    .o_level(rx_lock_sync)
  );

  // timeout selection; code 110 has no period and falls back to the reset period
  always_comb begin
    case (st_r.ld_sel)
      LD_CODE_162US: ld_limit = P_LD_CYC_162;
      LD_CODE_325US: ld_limit = P_LD_CYC_325;
      LD_CODE_650US: ld_limit = P_LD_CYC_650;
      LD_CODE_1300US: ld_limit = P_LD_CYC_1300;
      LD_CODE_10US: ld_limit = LD_CYC_10;
      LD_CODE_20US: ld_limit = P_LD_CYC_20;
      LD_CODE_82US: ld_limit = P_LD_CYC_82;
      default: ld_limit = P_LD_CYC_162;
    endcase
  end

  // every valid reverse-channel report restarts the watchdog
  rcl_link_timer u_link_timer (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_restart(i_bc.valid),
    .i_limit(ld_limit),
    .o_link_detect(link_detect),
    .o_expire(link_expire)
  );

  // previous link state, used only to spot the rising edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_prev_r <= 1'b0;
    end else begin
      link_prev_r <= link_detect;
    end
  end

  // bus handshake: one wait cycle prepares read data, the next edge completes
  assign req = i_avs_read | i_avs_write;
  assign prep = req & ~st_r.ack;
  assign wr_commit = i_avs_write & st_r.ack;
  assign wr_lane0 = wr_commit & i_avs_byteenable[0]; // registers live in byte lane 0
  assign o_avs_waitrequest = req & ~st_r.ack;

  // auto-load only while locked and not frozen
  assign bc_caps = caps_of(i_bc.caps);
  assign auto_load = i_bc.valid & rx_lock_sync & ~st_r.cap_lock;

  // events feeding the sticky interrupt status
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_LOADED] = auto_load & (bc_caps != st_r.caps);
    irq_event[IRQ_LINK_UP] = link_detect & ~link_prev_r;
    irq_event[IRQ_LINK_DOWN] = link_expire;
  end

  // read views of each register; reserved bits read as zero
  always_comb begin
    cap_a_view = 8'h00;
    cap_a_view[CAP_LOCK_BIT] = st_r.cap_lock;
    cap_a_view[SEND_FREQ_BIT] = st_r.caps.send_freq;
    cap_a_view[SEND_EQ_BIT] = st_r.caps.send_eq;
    cap_a_view[TWO_LANE_BIT] = st_r.caps.two_lane;
    cap_a_view[CHAN_SEL_BIT] = st_r.caps.chan_sel;
    cap_a_view[WIDE_VID_BIT] = st_r.caps.wide_video;
    cap_a_view[FWD_PIN_BIT] = st_r.caps.fwd_pin;
    ld_view = {5'h00, st_r.ld_sel};
    sts_view = 8'h00;
    sts_view[STS_LINK_BIT] = link_detect;
    sts_view[STS_LOCK_BIT] = rx_lock_sync;
  end

  // next state of the whole bank
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = prep;

    // read data is captured in the wait cycle so it stands from a flop at completion
    if (prep) begin
      if (addr_hit(i_avs_address, CAP_A_IDX)) begin
        st_nxt.rdata = {24'h000000, cap_a_view};
      end else if (addr_hit(i_avs_address, LD_CTRL_IDX)) begin
        st_nxt.rdata = {24'h000000, ld_view};
      end else if (addr_hit(i_avs_address, STATUS_IDX)) begin
        st_nxt.rdata = {24'h000000, sts_view};
      end else if (addr_hit(i_avs_address, IRQ_STS_IDX)) begin
        st_nxt.rdata = {29'h0, st_r.irq_sts};
      end else if (addr_hit(i_avs_address, IRQ_EN_IDX)) begin
        st_nxt.rdata = {29'h0, st_r.irq_en};
      end else begin
        st_nxt.rdata = 32'h00000000; // second capability byte, clear and unmapped read zero
      end
    end

    // software writes; software may set fields directly but only the freeze or a missing receiver lock keeps them
    if (wr_lane0) begin
      if (addr_hit(i_avs_address, CAP_A_IDX)) begin
        st_nxt.cap_lock = i_avs_writedata[CAP_LOCK_BIT];
        st_nxt.caps = caps_of(i_avs_writedata[7:0]);
      end else if (addr_hit(i_avs_address, LD_CTRL_IDX)) begin
        st_nxt.ld_sel = i_avs_writedata[2:0];
      end else if (addr_hit(i_avs_address, IRQ_EN_IDX)) begin
        st_nxt.irq_en = i_avs_writedata[IRQ_W-1:0];
      end
    end

    // the back channel overwrites a same-cycle software write when not frozen
    if (auto_load) begin
      st_nxt.caps = bc_caps;
    end

    // sticky status: a clear and a new event in one cycle leave the bit set
    if (wr_lane0 && addr_hit(i_avs_address, IRQ_CLR_IDX)) begin
      st_nxt.irq_sts = st_r.irq_sts & ~i_avs_writedata[IRQ_W-1:0];
    end
    st_nxt.irq_sts = st_nxt.irq_sts | irq_event;
  end

  // register the bank; capability and control fields start at their reset values
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.cap_lock <= CAP_A_RST[CAP_LOCK_BIT];
      st_r.caps <= '0;
      st_r.ld_sel <= LD_CTRL_RST;
      st_r.irq_sts <= '0;
      st_r.irq_en <= IRQ_EN_RST;
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign o_avs_readdata = st_r.rdata;
  assign o_caps = st_r.caps;
  assign o_send_eq_train = st_r.caps.send_eq;
  assign o_link_detect = link_detect;
  assign o_irq = |(st_r.irq_sts & st_r.irq_en); // level, high while an enabled bit is set

endmodule : rcl_top

//--- sim/rcl_deser_model.sv
// behavioural remote receiver sending capability reports on the back channel
`timescale 1ns/1ps
module rcl_deser_model
  import rcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_send,
  input wire logic [7:0] i_caps,
  input wire logic [3:0] i_delay,
  output rcl_bc_s o_bc
);
  logic pend_r = 1'b0;
  logic [3:0] cnt_r = 4'h0;
  logic [7:0] last_r = 8'h00;
  initial o_bc = '0;
  // report leaves after the asked delay; idle caps show the inverse so stale data never matches
  always @(posedge i_mclk) begin
    o_bc.valid <= pend_r && cnt_r == 4'h0;
    o_bc.caps <= (pend_r && cnt_r == 4'h0) ? last_r : ~last_r;
    if (i_send) begin
      pend_r <= 1'b1;
      cnt_r <= i_delay;
      last_r <= i_caps;
    end else if (pend_r) begin
      pend_r <= cnt_r != 4'h0;
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : rcl_deser_model

//--- sim/rcl_top_monitor.sv
// port checker of the capability bank, bound into rcl_top
`timescale 1ns/1ps
module rcl_top_monitor
  import rcl_pkg::*;
#(
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_162 = LD_CYC_162,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_325 = LD_CYC_325,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_650 = LD_CYC_650,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_1300 = LD_CYC_1300,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_20 = LD_CYC_20,
  parameter logic [LD_CNT_W-1:0] P_LD_CYC_82 = LD_CYC_82
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_rx_lock,
  input wire rcl_bc_s i_bc,
  input wire rcl_caps_s o_caps,
  input wire logic o_send_eq_train,
  input wire logic o_link_detect
);
  logic wr_ok;
  logic frz_r;
  logic [2:0] code_r;
  logic [3:0] lk_r;
  logic [LD_CNT_W-1:0] idle_r;
  logic [LD_CNT_W-1:0] lim;
  assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  // shadows of freeze, timeout code, lock age and quiet time, rebuilt from the ports
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frz_r <= 1'b0;
      code_r <= 3'h0;
      lk_r <= 4'h0;
      idle_r <= '0;
    end else begin
      if (wr_ok && i_avs_address == 8'h80) frz_r <= i_avs_writedata[CAP_LOCK_BIT];
      if (wr_ok && i_avs_address == 8'h98) code_r <= i_avs_writedata[2:0];
      lk_r <= !i_rx_lock ? 4'h0 : (lk_r == 4'h8 ? lk_r : lk_r + 4'h1);
      idle_r <= i_bc.valid ? '0 : (&idle_r ? idle_r : idle_r + 1'b1);
    end
  end
  // period per code; reserved 110 falls back to the 162us default period
  always_comb begin
    case (code_r)
      3'h1: lim = P_LD_CYC_325;
      3'h2: lim = P_LD_CYC_650;
      3'h3: lim = P_LD_CYC_1300;
      3'h4: lim = LD_CYC_10;
      3'h5: lim = P_LD_CYC_20;
      3'h7: lim = P_LD_CYC_82;
      default: lim = P_LD_CYC_162;
    endcase
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  eq_follow_a: assert property (o_send_eq_train == o_caps.send_eq)
    else $error("eq pattern not from cap bit");
  link_rise_a: assert property (i_bc.valid |=> o_link_detect)
    else $error("link detect not raised");
  auto_load_a: assert property (i_bc.valid && lk_r == 4'h8 && !frz_r
    |=> o_caps == $past(i_bc.caps[5:0])) else $error("report not loaded");
  frz_hold_a: assert property (frz_r && !(wr_ok && i_avs_address == 8'h80)
    |=> $stable(o_caps)) else $error("frozen caps moved");
  caps_cause_a: assert property ($changed(o_caps)
    |-> $past(i_bc.valid) || $past(wr_ok && i_avs_address == 8'h80)) else $error("caps moved");
  link_drop_a: assert property ($fell(o_link_detect) |-> idle_r == lim)
    else $error("link dropped at wrong time");
  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("wait state too long");
  rsvd_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h84
    |-> o_avs_readdata == 32'h00000000) else $error("reserved read not zero");
endmodule : rcl_top_monitor

bind rcl_top rcl_top_monitor #(.P_LD_CYC_162(P_LD_CYC_162), .P_LD_CYC_325(P_LD_CYC_325),
  .P_LD_CYC_650(P_LD_CYC_650), .P_LD_CYC_1300(P_LD_CYC_1300), .P_LD_CYC_20(P_LD_CYC_20),
  .P_LD_CYC_82(P_LD_CYC_82)) u_mon (.i_mclk, .i_rst_n, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .i_rx_lock, .i_bc, .o_caps, .o_send_eq_train, .o_link_detect);

//--- sim/remote_capability_and_link_detect_tb.sv
// self-checking bench of the capability bank against a remote receiver model
`timescale 1ns/1ps
module remote_capability_and_link_detect_tb
  import rcl_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq;
  logic lock = 1'b0;
  logic send = 1'b0;
  logic [7:0] scaps = 8'h00;
  logic [3:0] sdly = 4'h0;
  rcl_bc_s bc;
  rcl_caps_s caps;
  logic eq_tr;
  logic link;
  logic irq;
  int fail_count = 0;
  int samples_checked = 0;
  always #5 i_mclk = ~i_mclk;
  // short timeout counts keep the run brief; the 10.25us and 20.5us counts keep their real length
  rcl_top #(.P_LD_CYC_162(40), .P_LD_CYC_325(50), .P_LD_CYC_650(60), .P_LD_CYC_1300(70),
    .P_LD_CYC_82(35)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_rx_lock(lock), .i_bc(bc), .o_caps(caps), .o_send_eq_train(eq_tr),
    .o_link_detect(link), .o_irq(irq));
  rcl_deser_model peer (.i_mclk(i_mclk), .i_send(send), .i_caps(scaps), .i_delay(sdly),
    .o_bc(bc));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      $display("unexpected at %0t: wait ran out", $time);
      fail_count++;
      end_sim();
    end
  endtask : tmo
  // one avalon access; values read right after an edge are those sampled at it
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge i_mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    tmo(n, 50);
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rchk
  // ask the model for a report, return one edge after the block took it
  task automatic rep(input logic [7:0] c, input logic [3:0] dl);
    int n;
    n = 0;
    @(posedge i_mclk);
    send <= 1'b1;
    scaps <= c;
    sdly <= dl;
    @(posedge i_mclk);
    send <= 1'b0;
    while (bc.valid !== 1'b1 && n < 30) begin
      @(posedge i_mclk);
      n++;
    end
    tmo(n, 30);
    @(posedge i_mclk);
  endtask : rep
  task automatic t_reset();
    chk({24'h0, caps, link, irq}, 32'h0);
    rchk(8'h80, 32'h0);
    rchk(8'h98, 32'h0);
    rchk(8'h84, 32'h0);
    rchk(8'hfc, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_load();
    @(posedge i_mclk);
    lock <= 1'b1;
    bus(1'b1, 8'hac, 8'h07);
    repeat (6) @(posedge i_mclk);
    rep(8'h10, 4'h9);
    chk({29'h0, eq_tr, link, irq}, 32'h7);
    rchk(8'ha4, 32'h3);
    rchk(8'ha0, 32'h3);
    bus(1'b1, 8'ha8, 8'h03);
    @(posedge i_mclk);
    chk({31'h0, irq}, 32'h0);
    for (int b = 0; b < 4; b++) begin
      rep(8'h01 << b, 4'h0);
      chk({26'h0, caps}, 32'h1 << b);
    end
    rchk(8'h80, 32'h08);
    $display("test auto-load done");
  endtask : t_load
  task automatic t_freeze();
    bus(1'b1, 8'h80, 8'h85);
    rep(8'h3f, 4'h0);
    chk({26'h0, caps}, 32'h05);
    rchk(8'h80, 32'h85);
    bus(1'b1, 8'h80, 8'h00);
    rep(8'h2a, 4'h0);
    chk({26'h0, caps}, 32'h2a);
    @(posedge i_mclk);
    lock <= 1'b0;
    repeat (8) @(posedge i_mclk);
    rep(8'h15, 4'h0);
    chk({25'h0, caps, link}, 32'h55);
    $display("test freeze and lock done");
  endtask : t_freeze
  task automatic t_timeout();
    logic [2:0] cd [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6};
    int ex [8] = '{40, 50, 60, 70, 1025, 2050, 35, 40};
    int n;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (link !== 1'b0 && n < 2200) begin
        @(posedge i_mclk);
        n++;
      end
      tmo(n, 2200);
      bus(1'b1, 8'h98, {5'h00, cd[i]});
      rchk(8'h98, {29'h0, cd[i]});
      rep(8'h2a, 4'h0);
      n = 1;
      while (link === 1'b1 && n < 2200) begin
        @(posedge i_mclk);
        n += int'(link === 1'b1);
      end
      chk(n, ex[i]);
      bus(1'b0, 8'ha4, 8'h00);
      chk(q & 32'h4, 32'h4);
      // clear the loss flag so every code proves its own expiry
      bus(1'b1, 8'ha8, 8'h04);
    end
    bus(1'b1, 8'hac, 8'h00);
    @(posedge i_mclk);
    chk({31'h0, irq}, 32'h0);
    rchk(8'hac, 32'h0);
    // a write without byte lane 0 must leave the timeout code alone
    be <= 4'h0;
    bus(1'b1, 8'h98, 8'h01);
    be <= 4'hf;
    rchk(8'h98, 32'h6);
    $display("test link timeout done");
  endtask : t_timeout
  // reset, then the scenarios in order
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_load();
    t_freeze();
    t_timeout();
    end_sim();
  end
endmodule : remote_capability_and_link_detect_tb
